// [ssd_params.svh]
// Purpose: Constants for the system store and trap decoder
// Assumes: Included by bare name from the decoder, the core and the bench
// Notes: Offsets, fields, encodings and cycle counts live here
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

// ==========================================================
// Register map, byte addresses on APB
`define SSD_OFS_CTRL 8'h00
`define SSD_OFS_IRQ_STAT 8'h04
`define SSD_OFS_IRQ_MASK 8'h08
`define SSD_OFS_VBASE 8'h0c
`define SSD_OFS_SSTAT 8'h10
`define SSD_OFS_SPC 8'h14
`define SSD_OFS_EXC_IMM 8'h18
`define SSD_OFS_EXC_EVT 8'h1c

// ==========================================================
// Field positions and reset values
`define SSD_CTRL_DSP_BIT 0
`define SSD_IRQ_TRAP_BIT 0
`define SSD_IRQ_PRIV_BIT 1
`define SSD_IRQ_ILLEGAL_BIT 2
`define SSD_IRQ_W 3
`define SSD_MD_BIT 30
`define SSD_RST_WORD 32'h0000_0000

// ==========================================================
// Opcode fields
`define SSD_OP_GRP_HI 4'h4
`define SSD_OP_GRP_LO 4'h0
`define SSD_OP_TRAP 8'hc3
`define SSD_SUB_VBASE 8'h23
`define SSD_SUB_SSTAT 8'h33
`define SSD_SUB_SPC 8'h43
`define SSD_SUB_BANK_LO 4'h3
`define SSD_SUB_MAC_HIGH_WORD_PUSH 8'h02
`define SSD_SUB_MAC_LOW_WORD_PUSH 8'h12
`define SSD_SUB_PR_PUSH 8'h22
`define SSD_SUB_MAC_HIGH_WORD_MOVE 8'h0a
`define SSD_SUB_MAC_LOW_WORD_MOVE 8'h1a
`define SSD_SUB_PR_MOVE 8'h2a
`define SSD_SEL_VBASE 3'h2
`define SSD_SEL_SSTAT 3'h3
`define SSD_SEL_MAC_HIGH_WORD 3'h0
`define SSD_SEL_MAC_LOW_WORD 3'h1

// ==========================================================
// Exception constants and cycle counts
`define SSD_TRAP_EVENT 32'h0000_0160
`define SSD_TRAP_OFFSET 32'h0000_0100
`define SSD_PC_STEP 32'h0000_0002
`define SSD_STACK_STEP 32'h0000_0004
`define SSD_CYC_CTRL_BASE 4'h1
`define SSD_CYC_CTRL_DSP 4'h2
`define SSD_CYC_BANK 4'h2
`define SSD_CYC_SYS 4'h1
`define SSD_CYC_MOVE 4'h1
`define SSD_CYC_TRAP_BASE 4'h6
`define SSD_CYC_TRAP_DSP 4'h8
`define SSD_CNT_ONE 4'h1

`endif

// [ssd_pkg.sv]
// Purpose: Types shared by the decoder files
// Assumes: Compiled before all modules
// Notes: Numbers live in ssd_params.svh
package ssd_pkg;
   // Decoded operation class
   typedef enum logic [2:0] {
      SSD_OP_NONE,
      SSD_OP_PUSH_CTRL,
      SSD_OP_PUSH_BANK,
      SSD_OP_PUSH_SYS,
      SSD_OP_MOVE_SYS,
      SSD_OP_TRAP
   } ssd_op_t;
   // Sequencer states
   typedef enum logic [0:0] {
      SSD_ST_IDLE,
      SSD_ST_EXEC
   } ssd_state_t;
endpackage

// [ssd_decode.sv]
// Purpose: Classify an opcode of the system store and trap group
// Assumes: Purely combinational, same clock as the core
// Notes: Anything outside the group decodes to none
`timescale 1ns/1ps
`default_nettype none
`include "ssd_params.svh"
module ssd_decode (
   // Opcode in
   input wire logic [15:0] opcode,
   // Decoded class and selector
   output ssd_pkg::ssd_op_t op_kind,
   output logic [2:0] op_sel
);
   // ==========================================================
   // Opcode classification
   always_comb begin
      op_kind = ssd_pkg::SSD_OP_NONE;
      op_sel = opcode[6:4];
      if (opcode[15:8] == `SSD_OP_TRAP) begin
         op_kind = ssd_pkg::SSD_OP_TRAP;
      end else if (opcode[15:12] == `SSD_OP_GRP_HI) begin
         if (opcode[7:0] == `SSD_SUB_VBASE || opcode[7:0] == `SSD_SUB_SSTAT ||
             opcode[7:0] == `SSD_SUB_SPC) begin
            op_kind = ssd_pkg::SSD_OP_PUSH_CTRL;
         end else if (opcode[7] && opcode[3:0] == `SSD_SUB_BANK_LO) begin
            op_kind = ssd_pkg::SSD_OP_PUSH_BANK;
         end else if (opcode[7:0] == `SSD_SUB_MAC_HIGH_WORD_PUSH ||
                      opcode[7:0] == `SSD_SUB_MAC_LOW_WORD_PUSH ||
                      opcode[7:0] == `SSD_SUB_PR_PUSH) begin
            op_kind = ssd_pkg::SSD_OP_PUSH_SYS;
         end
      end else if (opcode[15:12] == `SSD_OP_GRP_LO) begin
         if (opcode[7:0] == `SSD_SUB_MAC_HIGH_WORD_MOVE || opcode[7:0] == `SSD_SUB_MAC_LOW_WORD_MOVE ||
             opcode[7:0] == `SSD_SUB_PR_MOVE) begin
            op_kind = ssd_pkg::SSD_OP_MOVE_SYS;
         end
      end
   end
endmodule
`default_nettype wire

// [ssd_cycle_cnt.sv]
// Purpose: Down counter for the remaining execution cycles
// Assumes: Load wins over decrement
// Notes: Holds at zero, never wraps
`timescale 1ns/1ps
`default_nettype none
module ssd_cycle_cnt #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   // State
   output logic [W-1:0] count,
   output logic zero
);
   // Counter register and next value
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // ==========================================================
   // Next count
   always_comb begin
      if (load) begin
         cnt_next = load_val;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - W'(1);
      end else begin
         cnt_next = cnt_reg;
      end
   end

   // Register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign count = cnt_reg;
   assign zero = (cnt_reg == '0);
endmodule
`default_nettype wire

// [ssd_core.sv]
// Purpose: Execute stack stores, system moves and software traps
// Assumes: Datapath supplies operand values with each opcode
// Notes: Registers on APB, one wait state per access
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_params.svh"
module ssd_core #(
   parameter int CNT_W = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction stream
   input wire logic instr_valid,
   input wire logic [15:0] instr_opcode,
   input wire logic [31:0] instr_pc,
   output logic instr_ready,
   output logic instr_done,
   output logic instr_fault,
   // Datapath operands
   input wire logic [31:0] status_word,
   input wire logic [31:0] dest_gpr_value,
   input wire logic [31:0] banked_gpr_value,
   input wire logic [31:0] mac_high_word,
   input wire logic [31:0] mac_low_word,
   input wire logic [31:0] return_address_reg,
   input wire logic load_hazard,
   // General register write back
   output logic gpr_we,
   output logic [3:0] gpr_waddr,
   output logic [31:0] gpr_wdata,
   // Data memory stores
   output logic mem_req,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   // Exception unit hand-off
   output logic branch_valid,
   output logic [31:0] branch_target,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // Declarations

   // Sequencer state
   ssd_pkg::ssd_state_t state_reg, state_next;
   // Latched operation
   ssd_pkg::ssd_op_t op_reg, op_next;
   logic [15:0] opc_reg, opc_next;
   logic [31:0] pc_reg, pc_next;
   logic [31:0] sw_reg, sw_next;
   // Store and write-back data
   logic [31:0] addr_reg, addr_next;
   logic [31:0] data_reg, data_next;
   // Memory handshake
   logic mreq_reg, mreq_next;
   // Output pulses, ready level and branch target
   logic ready_reg, ready_next;
   logic done_reg, done_next;
   logic fault_reg, fault_next;
   logic gwe_reg, gwe_next;
   logic br_reg, br_next;
   logic [31:0] brt_reg, brt_next;
   // Exception bookkeeping
   logic [31:0] vbase_reg, vbase_next;
   logic [31:0] sstat_reg, sstat_next;
   logic [31:0] spc_reg, spc_next;
   logic [31:0] eimm_reg, eimm_next;
   logic [31:0] eevt_reg, eevt_next;
   // Software control and interrupt
   logic dsp_reg, dsp_next;
   logic [`SSD_IRQ_W-1:0] ist_reg, ist_next;
   logic [`SSD_IRQ_W-1:0] imask_reg, imask_next;
   logic irq_reg, irq_next;
   // APB answer
   logic [31:0] prd_reg, prd_next;
   logic prdy_reg, prdy_next;
   logic perr_reg, perr_next;
   // Decoder and counter wires
   ssd_pkg::ssd_op_t dec_kind;
   logic [2:0] dec_sel;
   logic cnt_load;
   logic [CNT_W-1:0] cnt_val;
   logic [CNT_W-1:0] cnt_count;
   logic cnt_zero;
   // Events and helpers
   logic take;
   logic finish;
   logic ev_trap, ev_priv, ev_ill;
   logic privileged;
   logic apb_wr, apb_rd;

   // ==========================================================
   // Sub-blocks

   // Opcode classifier
   ssd_decode u_dec (
      .opcode(instr_opcode),
      .op_kind(dec_kind),
      .op_sel(dec_sel)
   );

   // Remaining execution cycles
   ssd_cycle_cnt #(.W(CNT_W)) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .load(cnt_load),
      .load_val(cnt_val),
      .count(cnt_count),
      .zero(cnt_zero)
   );

   // ==========================================================
   // Acceptance and cycle budget

   // Take an opcode only while idle and ready
   assign take = instr_valid && ready_reg && (state_reg == ssd_pkg::SSD_ST_IDLE);
   assign privileged = status_word[`SSD_MD_BIT];
   assign cnt_load = take;

   // Cycles minus one, the first cycle is the accept edge itself
   always_comb begin
      cnt_val = '0;
      case (dec_kind)
         ssd_pkg::SSD_OP_PUSH_CTRL: begin
            cnt_val = CNT_W'((dsp_reg ? `SSD_CYC_CTRL_DSP : `SSD_CYC_CTRL_BASE)
                      - `SSD_CNT_ONE);
         end
         ssd_pkg::SSD_OP_PUSH_BANK: begin
            cnt_val = CNT_W'(`SSD_CYC_BANK - `SSD_CNT_ONE);
         end
         ssd_pkg::SSD_OP_PUSH_SYS: begin
            cnt_val = CNT_W'(`SSD_CYC_SYS - `SSD_CNT_ONE);
         end
         ssd_pkg::SSD_OP_MOVE_SYS: begin
            cnt_val = CNT_W'(`SSD_CYC_MOVE - `SSD_CNT_ONE);
         end
         ssd_pkg::SSD_OP_TRAP: begin
            cnt_val = CNT_W'((dsp_reg ? `SSD_CYC_TRAP_DSP : `SSD_CYC_TRAP_BASE)
                      - `SSD_CNT_ONE);
         end
         default: begin
            cnt_val = '0;
         end
      endcase
   end

   // stretch on contention or load use
   assign finish = (state_reg == ssd_pkg::SSD_ST_EXEC) && cnt_zero &&
                   (!mreq_reg || mem_ack) && !load_hazard;

   // ==========================================================
   // Execution sequencer, next values
   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      opc_next = opc_reg;
      pc_next = pc_reg;
      sw_next = sw_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      mreq_next = mreq_reg;
      ready_next = ready_reg;
      done_next = 1'b0;
      fault_next = 1'b0;
      gwe_next = 1'b0;
      br_next = 1'b0;
      brt_next = brt_reg;
      sstat_next = sstat_reg;
      spc_next = spc_reg;
      eimm_next = eimm_reg;
      eevt_next = eevt_reg;
      ev_trap = 1'b0;
      ev_priv = 1'b0;
      ev_ill = 1'b0;
      case (state_reg)
         ssd_pkg::SSD_ST_IDLE: begin
            ready_next = 1'b1;
            if (take) begin
               op_next = dec_kind;
               opc_next = instr_opcode;
               pc_next = instr_pc;
               sw_next = status_word;
               // Pre-decremented stack address
               addr_next = dest_gpr_value - `SSD_STACK_STEP;
               data_next = `SSD_RST_WORD;
               case (dec_kind)
                  ssd_pkg::SSD_OP_PUSH_CTRL: begin
                     if (dec_sel == `SSD_SEL_VBASE) begin
                        data_next = vbase_reg;
                     end else if (dec_sel == `SSD_SEL_SSTAT) begin
                        data_next = sstat_reg;
                     end else begin
                        data_next = spc_reg;
                     end
                  end
                  ssd_pkg::SSD_OP_PUSH_BANK: begin
                     data_next = banked_gpr_value;
                  end
                  ssd_pkg::SSD_OP_PUSH_SYS, ssd_pkg::SSD_OP_MOVE_SYS: begin
                     if (dec_sel == `SSD_SEL_MAC_HIGH_WORD) begin
                        data_next = mac_high_word;
                     end else if (dec_sel == `SSD_SEL_MAC_LOW_WORD) begin
                        data_next = mac_low_word;
                     end else begin
                        data_next = return_address_reg;
                     end
                  end
                  default: begin
                     data_next = `SSD_RST_WORD;
                  end
               endcase
               ready_next = 1'b0;
               if ((dec_kind == ssd_pkg::SSD_OP_PUSH_CTRL ||
                    dec_kind == ssd_pkg::SSD_OP_PUSH_BANK) && !privileged) begin
                  ev_priv = 1'b1;
                  fault_next = 1'b1;
                  done_next = 1'b1;
                  ready_next = 1'b1;
               end else if (dec_kind == ssd_pkg::SSD_OP_NONE) begin
                  // Foreign opcode, refused at once
                  ev_ill = 1'b1;
                  fault_next = 1'b1;
                  done_next = 1'b1;
                  ready_next = 1'b1;
               end else begin
                  state_next = ssd_pkg::SSD_ST_EXEC;
                  mreq_next = (dec_kind == ssd_pkg::SSD_OP_PUSH_CTRL) ||
                              (dec_kind == ssd_pkg::SSD_OP_PUSH_BANK) ||
                              (dec_kind == ssd_pkg::SSD_OP_PUSH_SYS);
               end
            end
         end
         ssd_pkg::SSD_ST_EXEC: begin
            // Store request drops once accepted
            if (mreq_reg && mem_ack) begin
               mreq_next = 1'b0;
            end
            if (finish) begin
               state_next = ssd_pkg::SSD_ST_IDLE;
               ready_next = 1'b1;
               done_next = 1'b1;
               if (op_reg == ssd_pkg::SSD_OP_TRAP) begin
                  spc_next = pc_reg + `SSD_PC_STEP;
                  sstat_next = sw_reg;
                  eimm_next = {22'h0, opc_reg[7:0], 2'h0};
                  eevt_next = `SSD_TRAP_EVENT;
                  brt_next = vbase_reg + `SSD_TRAP_OFFSET;
                  br_next = 1'b1;
                  ev_trap = 1'b1;
               end else begin
                  // Pushes write back the lowered pointer, moves the value
                  gwe_next = 1'b1;
                  if (op_reg == ssd_pkg::SSD_OP_MOVE_SYS) begin
                     addr_next = data_reg;
                  end
               end
            end
         end
         default: begin
            state_next = ssd_pkg::SSD_ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ssd_pkg::SSD_ST_IDLE;
         op_reg <= ssd_pkg::SSD_OP_NONE;
         opc_reg <= 16'h0000;
         pc_reg <= `SSD_RST_WORD;
         sw_reg <= `SSD_RST_WORD;
         addr_reg <= `SSD_RST_WORD;
         data_reg <= `SSD_RST_WORD;
         mreq_reg <= 1'b0;
         ready_reg <= 1'b0;
         done_reg <= 1'b0;
         fault_reg <= 1'b0;
         gwe_reg <= 1'b0;
         br_reg <= 1'b0;
         brt_reg <= `SSD_RST_WORD;
         sstat_reg <= `SSD_RST_WORD;
         spc_reg <= `SSD_RST_WORD;
         eimm_reg <= `SSD_RST_WORD;
         eevt_reg <= `SSD_RST_WORD;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         opc_reg <= opc_next;
         pc_reg <= pc_next;
         sw_reg <= sw_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         mreq_reg <= mreq_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
         fault_reg <= fault_next;
         gwe_reg <= gwe_next;
         br_reg <= br_next;
         brt_reg <= brt_next;
         sstat_reg <= sstat_next;
         spc_reg <= spc_next;
         eimm_reg <= eimm_next;
         eevt_reg <= eevt_next;
      end
   end

   // ==========================================================
   // APB registers, next values
   assign apb_wr = psel && penable && pwrite && !prdy_reg;
   assign apb_rd = psel && penable && !pwrite && !prdy_reg;

   always_comb begin
      dsp_next = dsp_reg;
      vbase_next = vbase_reg;
      imask_next = imask_reg;
      ist_next = ist_reg;
      prd_next = prd_reg;
      perr_next = 1'b0;
      // One wait state keeps pready a plain flop
      prdy_next = psel && penable && !prdy_reg;
      if (apb_wr) begin
         case (paddr)
            `SSD_OFS_CTRL: dsp_next = pwdata[`SSD_CTRL_DSP_BIT];
            `SSD_OFS_IRQ_STAT: ist_next = ist_reg & ~pwdata[`SSD_IRQ_W-1:0];
            `SSD_OFS_IRQ_MASK: imask_next = pwdata[`SSD_IRQ_W-1:0];
            `SSD_OFS_VBASE: vbase_next = pwdata;
            `SSD_OFS_SSTAT, `SSD_OFS_SPC, `SSD_OFS_EXC_IMM, `SSD_OFS_EXC_EVT: begin
               perr_next = 1'b0;
            end
            default: perr_next = 1'b1;
         endcase
      end
      if (apb_rd) begin
         case (paddr)
            `SSD_OFS_CTRL: prd_next = {31'h0, dsp_reg};
            `SSD_OFS_IRQ_STAT: prd_next = {29'h0, ist_reg};
            `SSD_OFS_IRQ_MASK: prd_next = {29'h0, imask_reg};
            `SSD_OFS_VBASE: prd_next = vbase_reg;
            `SSD_OFS_SSTAT: prd_next = sstat_reg;
            `SSD_OFS_SPC: prd_next = spc_reg;
            `SSD_OFS_EXC_IMM: prd_next = eimm_reg;
            `SSD_OFS_EXC_EVT: prd_next = eevt_reg;
            default: begin
               prd_next = `SSD_RST_WORD;
               perr_next = 1'b1;
            end
         endcase
      end
      // Events set after the clear so a same-cycle event is kept
      if (ev_trap) begin
         ist_next[`SSD_IRQ_TRAP_BIT] = 1'b1;
      end
      if (ev_priv) begin
         ist_next[`SSD_IRQ_PRIV_BIT] = 1'b1;
      end
      if (ev_ill) begin
         ist_next[`SSD_IRQ_ILLEGAL_BIT] = 1'b1;
      end
      irq_next = |(ist_next & imask_next);
   end

   // APB and interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dsp_reg <= 1'b0;
         vbase_reg <= `SSD_RST_WORD;
         imask_reg <= '0;
         ist_reg <= '0;
         irq_reg <= 1'b0;
         prd_reg <= `SSD_RST_WORD;
         prdy_reg <= 1'b0;
         perr_reg <= 1'b0;
      end else begin
         dsp_reg <= dsp_next;
         vbase_reg <= vbase_next;
         imask_reg <= imask_next;
         ist_reg <= ist_next;
         irq_reg <= irq_next;
         prd_reg <= prd_next;
         prdy_reg <= prdy_next;
         perr_reg <= perr_next;
      end
   end

   // ==========================================================
   // Outputs, all straight from flops
   assign prdata = prd_reg;
   assign pready = prdy_reg;
   assign pslverr = perr_reg;
   assign instr_ready = ready_reg;
   assign instr_done = done_reg;
   assign instr_fault = fault_reg;
   assign gpr_we = gwe_reg;
   assign gpr_waddr = opc_reg[11:8];
   assign gpr_wdata = addr_reg;
   assign mem_req = mreq_reg;
   assign mem_addr = addr_reg;
   assign mem_wdata = data_reg;
   assign branch_valid = br_reg;
   assign branch_target = brt_reg;
   assign irq = irq_reg;
endmodule
`default_nettype wire

// [ssd_checker.sv]
// Purpose: Port checks for ssd_core
// Assumes: One clock domain
// Notes: Sees only top level ports
`timescale 1ns/1ps
`default_nettype none
module ssd_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Instruction side
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic [15:0] instr_opcode,
   input wire logic [31:0] status_word,
   input wire logic [31:0] dest_gpr_value,
   input wire logic instr_done,
   input wire logic instr_fault,
   input wire logic gpr_we,
   input wire logic branch_valid,
   // Memory side
   input wire logic mem_req,
   input wire logic mem_ack,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Opcode taken
   wire logic take = instr_valid && instr_ready;
   // ========
   // Take sequences
   sequence s_take_ctrl;
      take && instr_opcode[15:12] == 4'h4 && instr_opcode[3:0] == 4'h3 && !status_word[30];
   endsequence
   sequence s_take_trap;
      take && instr_opcode[15:8] == 8'hc3;
   endsequence
   sequence s_take_move;
      take && instr_opcode[15:12] == 4'h0 && instr_opcode[3:0] == 4'ha;
   endsequence
   // ========
   // Properties
   property p_priv_refuse;
      s_take_ctrl |=> instr_done && instr_fault && !mem_req;
   endproperty
   a_priv_refuse: assert property (p_priv_refuse) else $error("privileged push ran");
   property p_refuse_quiet;
      instr_fault |-> !gpr_we && !branch_valid;
   endproperty
   a_refuse_quiet: assert property (p_refuse_quiet) else $error("refused op wrote");
   property p_store_addr;
      $rose(mem_req) |-> mem_addr == $past(dest_gpr_value) - 32'h4;
   endproperty
   a_store_addr: assert property (p_store_addr) else $error("store address wrong");
   property p_mem_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("store dropped early");
   property p_mem_drop;
      mem_req && mem_ack |=> !mem_req;
   endproperty
   a_mem_drop: assert property (p_mem_drop) else $error("store held after ack");
   property p_trap_time;
      s_take_trap |=> !instr_done [*5] ##[1:30] instr_done;
   endproperty
   a_trap_time: assert property (p_trap_time) else $error("trap too short");
   property p_branch_done;
      branch_valid |-> instr_done && !instr_fault;
   endproperty
   a_branch_done: assert property (p_branch_done) else $error("stray branch");
   property p_move_nostore;
      s_take_move |=> !mem_req;
   endproperty
   a_move_nostore: assert property (p_move_nostore) else $error("move stored");
endmodule
`default_nettype wire

// [ssd_mem_model.sv]
// Purpose: Stack store memory
// Assumes: Store lands on mem_ack
// Notes: Slow mode waits before acking
`timescale 1ns/1ps
`default_nettype none
module ssd_mem_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Store port
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   // Mode and record
   input wire logic fast,
   input wire logic [3:0] wait_n,
   output logic [31:0] st_addr,
   output logic [31:0] st_data,
   output int n_st
);
   logic ack_q;
   logic [3:0] cnt;
   // Fast mode answers at once
   assign mem_ack = fast | ack_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         cnt <= 4'h0;
         n_st <= 0;
      end else if (mem_req && !mem_ack) begin
         ack_q <= (cnt >= wait_n);
         cnt <= (cnt >= wait_n) ? 4'h0 : cnt + 4'h1;
      end else begin
         ack_q <= 1'b0;
         if (mem_req) begin
            st_addr <= mem_addr;
            st_data <= mem_wdata;
            n_st <= n_st + 1;
         end
      end
   end
endmodule
`default_nettype wire

// [ssd_tb_top.sv]
// Purpose: Self-checking bench for ssd_core
// Assumes: Drives at rising edges
// Notes: Latencies compared as differences
`timescale 1ns/1ps
`default_nettype none
`include "ssd_params.svh"
module ssd_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic instr_valid = 1'b0, hz = 1'b0, fast = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [15:0] opcode = 16'h0;
   logic [31:0] pwdata = 32'h0, bv = 32'h0, pc = 32'h0000_0200;
   logic [31:0] sw = 32'h4000_0001, dv = 32'h0000_1000;
   logic pready, pslverr, instr_ready, instr_done, instr_fault, gpr_we, mem_req, mem_ack;
   logic branch_valid, irq;
   logic [3:0] waddr, c_wa;
   logic [31:0] prdata, wdata, maddr, mwdata, btgt, st_addr, st_data, rd, c_wd, c_bt;
   logic [31:0] xv [3];
   logic err, c_fault, c_br;
   int fails = 0;
   int n_tests = 0;
   int n_st, lat, tl, l1, lm, nst;
   ssd_core #(.CNT_W(4)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .instr_valid, .instr_opcode(opcode), .instr_pc(pc), .instr_ready,
      .instr_done, .instr_fault, .status_word(sw), .dest_gpr_value(dv),
      .banked_gpr_value(bv), .mac_high_word(32'h1111_2222), .mac_low_word(32'h3333_4444),
      .return_address_reg(32'h5555_6666), .load_hazard(hz), .gpr_we, .gpr_waddr(waddr),
      .gpr_wdata(wdata), .mem_req, .mem_addr(maddr), .mem_wdata(mwdata), .mem_ack,
      .branch_valid, .branch_target(btgt), .irq);
   ssd_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_addr(maddr),
      .mem_wdata(mwdata), .mem_ack, .fast, .wait_n(4'h3), .st_addr, .st_data, .n_st);
   initial forever #4 pclk = ~pclk;
   task finish_test;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One APB transfer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One opcode, edges to done
   task run(input logic [15:0] op, input logic [31:0] b);
      @(posedge pclk);
      instr_valid <= 1'b1;
      opcode <= op;
      bv <= b;
      do @(posedge pclk); while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
      lat = 0;
      do begin
         @(posedge pclk);
         lat++;
         if (lat == 2) hz <= 1'b0;
      end while (instr_done !== 1'b1 && lat < 60);
      if (lat >= 60) fails++;
      c_wd = wdata;
      c_wa = waddr;
      c_fault = instr_fault;
      c_br = branch_valid;
      c_bt = btgt;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      finish_test;
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h20, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, `SSD_OFS_VBASE, 32'h8000_0000);
      run(16'hc325, 32'h0);
      tl = lat;
      chk(32'(c_br), 32'h1);
      chk(c_bt, 32'h8000_0100);
      apb(1'b0, `SSD_OFS_SSTAT, 32'h0);
      chk(rd, sw);
      apb(1'b0, `SSD_OFS_SPC, 32'h0);
      chk(rd, pc + 32'h2);
      apb(1'b0, `SSD_OFS_EXC_IMM, 32'h0);
      chk(rd, 32'h94);
      apb(1'b0, `SSD_OFS_EXC_EVT, 32'h0);
      chk(rd, 32'h160);
      apb(1'b1, `SSD_OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      apb(1'b1, `SSD_OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      $display("trap test done");
      xv = '{32'h8000_0000, sw, pc + 32'h2};
      for (int i = 0; i < 3; i++) begin
         run(16'h4523 + 16'(i * 16), 32'h0);
         chk(st_data, xv[i]);
         chk(st_addr, dv - 32'h4);
         chk(c_wd, dv - 32'h4);
      end
      l1 = lat;
      for (int k = 0; k < 8; k++) begin
         run(16'h4583 + 16'(k * 16), 32'hb0 + 32'(k));
         chk(st_data, 32'hb0 + 32'(k));
         chk(32'(lat), 32'(l1 + 1));
      end
      $display("push test done");
      @(posedge pclk);
      sw <= 32'h0000_0001;
      fast <= 1'b0;
      xv = '{32'h1111_2222, 32'h3333_4444, 32'h5555_6666};
      for (int i = 0; i < 3; i++) begin
         run(16'h4502 + 16'(i * 16), 32'h0);
         chk(st_data, xv[i]);
      end
      nst = n_st;
      run(16'h4523, 32'h0);
      chk(32'(c_fault), 32'h1);
      run(16'h45b3, 32'h0);
      chk(32'(c_fault), 32'h1);
      run(16'h0009, 32'h0);
      chk(32'(n_st), 32'(nst));
      for (int i = 0; i < 3; i++) begin
         run(16'h050a + 16'(i * 16), 32'h0);
         chk(c_wd, xv[i]);
         chk(32'(c_wa), 32'h5);
      end
      lm = lat;
      @(posedge pclk);
      hz <= 1'b1;
      run(16'h050a, 32'h0);
      chk(32'(lat > lm), 32'h1);
      $display("store test done");
      @(posedge pclk);
      sw <= 32'h4000_0001;
      fast <= 1'b1;
      apb(1'b1, `SSD_OFS_CTRL, 32'h1);
      run(16'hc301, 32'h0);
      chk(32'(lat), 32'(tl + 2));
      run(16'h4523, 32'h0);
      chk(32'(lat), 32'(l1 + 1));
      $display("dsp test done");
      finish_test;
   end
endmodule
bind ssd_core ssd_checker u_chk (.pclk, .presetn, .instr_valid, .instr_ready, .instr_opcode,
   .status_word, .dest_gpr_value, .instr_done, .instr_fault, .gpr_we, .branch_valid,
   .mem_req, .mem_ack, .mem_addr, .mem_wdata);
`default_nettype wire
